// ---- src/hex_counter_control.sv ----
`timescale 1ns/100ps
module hex_counter_control (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  // User side
  input wire logic [1:0] userMode,
  input wire logic [3:0] userPreset,
  input wire logic userEnable,
  output logic [3:0] userCount,
  output logic userTerminal,
  // Link
  hex_counter_if.control link
);
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [3:0] preset;
  logic [3:0] next_preset;
  logic enable_n;
  logic next_enable_n;
  logic [3:0] next_userCount;
  logic next_userTerminal;

  // ----------------------------------------
  // Steering of mode, preset, enable and the returned count and terminal lines
  // ----------------------------------------
  always_comb begin
    next_mode = userMode;
    next_preset = userPreset;
    next_enable_n = ~userEnable;
    next_userCount = link.countBits;
    next_userTerminal = ~link.terminalCount_n;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode <= hex_counter_pkg::MODE_HOLD;
      preset <= hex_counter_pkg::COUNT_RESET;
      enable_n <= 1'b1;
      userCount <= hex_counter_pkg::COUNT_RESET;
      userTerminal <= 1'b0;
    end else if (clkEn) begin
      mode <= next_mode;
      preset <= next_preset;
      enable_n <= next_enable_n;
      userCount <= next_userCount;
      userTerminal <= next_userTerminal;
    end
  end

  assign link.modeSelectHi = mode[1];
  assign link.modeSelectLo = mode[0];
  assign link.presetBits = preset;
  assign link.rippleEnable_n = enable_n;
endmodule : hex_counter_control

// ---- src/hex_counter_if.sv ----
`timescale 1ns/100ps
interface hex_counter_if;
  logic modeSelectHi;
  logic modeSelectLo;
  logic [3:0] presetBits;
  logic rippleEnable_n;
  logic [3:0] countBits;
  logic terminalCount_n;

  modport counter (
    input modeSelectHi,
    input modeSelectLo,
    input presetBits,
    input rippleEnable_n,
    output countBits,
    output terminalCount_n
  );
  modport control (
    output modeSelectHi,
    output modeSelectLo,
    output presetBits,
    output rippleEnable_n,
    input countBits,
    input terminalCount_n
  );
endinterface : hex_counter_if

// ---- src/hex_counter_pkg.sv ----
package hex_counter_pkg;
  // ----------------------------------------
  // Widths and values
  // ----------------------------------------
  localparam int COUNT_WIDTH = 4;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_MAX = 4'hF;
  localparam logic [3:0] COUNT_MIN = 4'h0;
  localparam logic [3:0] COUNT_STEP = 4'h1;

  // ----------------------------------------
  // Modes as {mode_select_hi, mode_select_lo}
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_PRESET = 2'h0,
    MODE_UP = 2'h1,
    MODE_DOWN = 2'h2,
    MODE_HOLD = 2'h3
  } mode_type;
endpackage : hex_counter_pkg

// ---- src/universal_hex_updown_counter.sv ----
`timescale 1ns/100ps
module universal_hex_updown_counter (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  // Link
  hex_counter_if.counter link
);
  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic hex_counter_pkg::mode_type decodeMode(
    input logic hi,
    input logic lo
  );
    case ({hi, lo})
      2'h0: begin
        decodeMode = hex_counter_pkg::MODE_PRESET;
      end
      2'h1: begin
        decodeMode = hex_counter_pkg::MODE_UP;
      end
      2'h2: begin
        decodeMode = hex_counter_pkg::MODE_DOWN;
      end
      default: begin
        decodeMode = hex_counter_pkg::MODE_HOLD;
      end
    endcase
  endfunction : decodeMode

  function automatic logic isCounting(
    input hex_counter_pkg::mode_type m
  );
    isCounting = 1'b0;
    case (m)
      hex_counter_pkg::MODE_UP: begin
        isCounting = 1'b1;
      end
      hex_counter_pkg::MODE_DOWN: begin
        isCounting = 1'b1;
      end
      default: begin
        isCounting = 1'b0;
      end
    endcase
  endfunction : isCounting

  function automatic logic atEnd(
    input hex_counter_pkg::mode_type m,
    input logic [3:0] value
  );
    atEnd = 1'b0;
    case (m)
      hex_counter_pkg::MODE_UP: begin
        atEnd = (value == hex_counter_pkg::COUNT_MAX);
      end
      hex_counter_pkg::MODE_DOWN: begin
        atEnd = (value == hex_counter_pkg::COUNT_MIN);
      end
      default: begin
        atEnd = 1'b0;
      end
    endcase
  endfunction : atEnd

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  hex_counter_pkg::mode_type mode;
  logic [3:0] count;
  logic [3:0] next_count;

  logic [3:0] stepped;
  logic [3:0] toggle;
  logic [3:0] chain;

  logic enabled;
  logic counting;
  logic countingDown;
  logic advance;
  logic terminalNow;

  logic presetBit0;
  logic presetBit1;
  logic presetBit2;
  logic presetBit3;

  logic countBit0;
  logic countBit1;
  logic countBit2;
  logic countBit3;

  // ----------------------------------------
  // Named pins, bit 0 least significant
  // ----------------------------------------
  assign presetBit0 = link.presetBits[0];
  assign presetBit1 = link.presetBits[1];
  assign presetBit2 = link.presetBits[2];
  assign presetBit3 = link.presetBits[3];

  // ----------------------------------------
  // Mode and enable qualification
  // ----------------------------------------
  assign mode = decodeMode(link.modeSelectHi, link.modeSelectLo);
  // Unknown or floating enable counts as active
  assign enabled = (link.rippleEnable_n !== 1'b1);
  assign counting = isCounting(mode);
  assign countingDown = (mode == hex_counter_pkg::MODE_DOWN);

  always_comb begin
    advance = 1'b0;
    if (counting) begin
      advance = enabled;
    end else begin
      advance = 1'b0;
    end
  end

  // ----------------------------------------
  // Carry and borrow chain
  // ----------------------------------------
  assign chain[0] = 1'b1;

  genvar bitIdx;

  generate
    for (bitIdx = 0; bitIdx < hex_counter_pkg::COUNT_WIDTH;
      bitIdx = bitIdx + 1) begin : g_chain
      // Bit flips when every lower bit sits at its end value
      assign toggle[bitIdx] = advance & chain[bitIdx];
      assign stepped[bitIdx] = count[bitIdx] ^ toggle[bitIdx];
      if (bitIdx < hex_counter_pkg::COUNT_WIDTH - 1) begin : g_link
        assign chain[bitIdx + 1] = chain[bitIdx] & (countingDown ?
          ~count[bitIdx] : count[bitIdx]);
      end
    end
  endgenerate

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    next_count = count;
    case (mode)
      hex_counter_pkg::MODE_PRESET: begin
        next_count = {presetBit3, presetBit2, presetBit1, presetBit0};
      end
      hex_counter_pkg::MODE_UP: begin
        next_count = stepped;
      end
      hex_counter_pkg::MODE_DOWN: begin
        next_count = stepped;
      end
      default: begin
        next_count = count;
      end
    endcase
  end

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= hex_counter_pkg::COUNT_RESET;
    end else if (clkEn) begin
      count <= next_count;
    end else begin
      count <= count;
    end
  end

  // ----------------------------------------
  // Terminal count
  // ----------------------------------------
  always_comb begin
    terminalNow = 1'b0;
    case (mode)
      hex_counter_pkg::MODE_PRESET: begin
        terminalNow = 1'b1;
      end
      hex_counter_pkg::MODE_UP: begin
        terminalNow = advance && atEnd(mode, count);
      end
      hex_counter_pkg::MODE_DOWN: begin
        terminalNow = advance && atEnd(mode, count);
      end
      default: begin
        terminalNow = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign countBit0 = count[0];
  assign countBit1 = count[1];
  assign countBit2 = count[2];
  assign countBit3 = count[3];

  assign link.countBits = {countBit3, countBit2, countBit1, countBit0};
  assign link.terminalCount_n = ~terminalNow;
endmodule : universal_hex_updown_counter

// ---- verif/hex_counter_properties.sv ----
`timescale 1ns/100ps
module hex_counter_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  // Link
  input wire logic modeSelectHi,
  input wire logic modeSelectLo,
  input wire logic [3:0] presetBits,
  input wire logic rippleEnable_n,
  input wire logic [3:0] countBits,
  input wire logic terminalCount_n
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  wire logic isPre = !modeSelectHi && !modeSelectLo;
  wire logic isUp = !modeSelectHi && modeSelectLo;
  wire logic isDn = modeSelectHi && !modeSelectLo;
  a_preset_load: assert property (clkEn && isPre |=>
    countBits == $past(presetBits)) else $error("no load");
  a_count_up: assert property (clkEn && isUp && !rippleEnable_n |=>
    countBits == $past(countBits) + 4'h1) else $error("bad up");
  a_count_down: assert property (clkEn && isDn && !rippleEnable_n |=>
    countBits == $past(countBits) - 4'h1) else $error("bad down");
  a_blocked_hold: assert property ((isUp || isDn) && rippleEnable_n |=>
    $stable(countBits)) else $error("blocked moved");
  a_hold_mode: assert property (modeSelectHi && modeSelectLo |=>
    $stable(countBits)) else $error("hold moved");
  a_preset_carry: assert property (isPre |-> !terminalCount_n)
    else $error("preset carry");
  a_end_carry: assert property (!rippleEnable_n && (isUp &&
    countBits == 4'hF || isDn && countBits == 4'h0) |-> !terminalCount_n)
    else $error("end carry");
  a_gated_carry: assert property ((isUp || isDn) && rippleEnable_n
    |-> terminalCount_n) else $error("gated carry");
  a_freeze_hold: assert property (!clkEn |=> $stable(countBits))
    else $error("frozen count moved");
endmodule : hex_counter_properties

// ---- verif/universal_hex_updown_counter_tb.sv ----
`timescale 1ns/100ps
module universal_hex_updown_counter_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] userMode = 2'h3;
  logic [3:0] userPreset = 4'h0;
  logic userEnable = 1'b1;
  logic [3:0] userCount;
  logic clkEn = 1'b1;
  logic userTerminal;
  int n;
  int fail_count = 0;
  int comparisons = 0;
  hex_counter_if link ();
  universal_hex_updown_counter universal_hex_updown_counter_i (.clk_sys,
    .rst_b, .clkEn, .link(link.counter));
  hex_counter_control hex_counter_control_i (.clk_sys, .rst_b, .clkEn,
    .userMode, .userPreset, .userEnable, .userCount, .userTerminal,
    .link(link.control));
  hex_counter_properties hex_counter_properties_i (.clk_sys, .rst_b,
    .clkEn, .modeSelectHi(link.modeSelectHi),
    .modeSelectLo(link.modeSelectLo), .presetBits(link.presetBits),
    .rippleEnable_n(link.rippleEnable_n), .countBits(link.countBits),
    .terminalCount_n(link.terminalCount_n));
  initial forever #50 clk_sys = ~clk_sys;
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task step(input logic [1:0] m, input logic [3:0] p, input logic en,
    input int n, input logic [3:0] exp);
    userMode = m;
    userPreset = p;
    userEnable = en;
    repeat (n) @(negedge clk_sys);
    userMode = 2'h3;
    repeat (3) @(negedge clk_sys);
    comparisons++;
    if (userCount !== exp || link.countBits !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, userCount, exp);
    end
  endtask : step
  task check(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    step(2'h0, 4'hC, 1'b1, 1, 4'hC);
    step(2'h1, 4'h0, 1'b1, 3, 4'hF);
    step(2'h1, 4'h0, 1'b0, 3, 4'hF);
    step(2'h1, 4'h0, 1'b1, 1, 4'h0);
    step(2'h2, 4'h0, 1'b1, 1, 4'hF);
    step(2'h3, 4'h5, 1'b1, 2, 4'hF);
    step(2'h2, 4'h0, 1'b1, 2, 4'hD);
    step(2'h0, 4'h3, 1'b0, 1, 4'h3);
    userMode = 2'h1;
    userEnable = 1'b0;
    @(negedge clk_sys);
    check({3'h0, link.terminalCount_n}, 4'h1);
    userMode = 2'h0;
    userPreset = 4'hF;
    @(negedge clk_sys);
    check({3'h0, link.terminalCount_n}, 4'h0);
    userMode = 2'h1;
    userEnable = 1'b1;
    @(negedge clk_sys);
    check({3'h0, link.terminalCount_n}, 4'h0);
    userMode = 2'h3;
    @(negedge clk_sys);
    check({3'h0, link.terminalCount_n}, 4'h1);
    check({3'h0, userTerminal}, 4'h1);
    check(link.countBits, 4'h0);
    clkEn = 1'b0;
    userMode = 2'h1;
    repeat (3) @(negedge clk_sys);
    check(link.countBits, 4'h0);
    clkEn = 1'b1;
    userMode = 2'h3;
    userPreset = 4'h4;
    @(negedge clk_sys);
    userMode = 2'h0;
    repeat (2) @(negedge clk_sys);
    userMode = 2'h2;
    @(negedge clk_sys);
    n = 1;
    while (link.terminalCount_n && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    userMode = 2'h3;
    check(n[3:0], 4'h5);
    close_out();
  end
  initial begin
    #50000;
    fail_count++;
    close_out();
  end
endmodule : universal_hex_updown_counter_tb
